// ===== verilog/spi_gain_mux_slave_daisy.sv
// Serial command port of a gain amplifier with input multiplexer.
// Assumes a host SPI master; pins are sampled by sys_clk at 125 MHz.
`timescale 1ns/1ns

// Contract
// - Works in modes 0,0 and 1,1.
// - Sample on rising, change on falling.
// - Non-multiple-of-16 frames are discarded.
// - Chip select fall resets bit alignment.
// - Apply command only at chip select rise.
// - Four-wire output driven only while selected.
// - Three-wire driver off while deselected.
// - Three-wire pin drives after a read.
// - Input bits pass through to output.
// - Chain variant decodes daisy command set.
// - Daisy no-op changes nothing.
// - Sixteen clocks per chained device.
// - Gain bits 7-4, channel bits 3-0.
// - Shutdown enter/leave; write leaves shutdown.
// - Gain and channel reset to zero.
module spi_gain_mux_slave_daisy
	import spi_gm_pkg::*;
#(
	parameter bit THREE_WIRE = 1'b0
)(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	input wire logic shared_data_pin_in,
	output logic shared_data_pin_out,
	output logic shared_data_pin_oe,
	output spi_gm_pkg::gain_code_t gain_code,
	output spi_gm_pkg::channel_code_t channel_code,
	output logic power_down,
	output logic frame_accepted
);
	import spi_gm_pkg::*;

	// Bit counter must wrap exactly once per frame
	if (FRAME_BITS != (1 << COUNT_W)) begin : g_bad_frame
		$error("Frame length must equal the counter modulus");
	end

	spi_pins_if pins ();

	spi_pin_sync u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.sclk(sclk),
		.cs_n(cs_n),
		.din(din),
		.shared_in_pin(shared_data_pin_in),
		.pins(pins)
	);

	frame_t shift_reg;
	frame_t shift_next;
	logic [COUNT_W-1:0] count_reg;
	logic full_word_reg;
	logic rose_reg;
	logic read_pending_reg;
	gain_code_t gain_reg;
	channel_code_t channel_reg;
	logic power_down_reg;
	logic dout_reg;
	logic dout_oe_reg;
	logic shared_out_reg;
	logic shared_oe_reg;
	logic accepted_reg;

	wire serial_in;
	wire sample;
	wire shift_out;
	wire length_ok;
	wire frame_ok;
	wire [7:0] opcode;
	wire [7:0] read_op;
	wire [7:0] write_op;
	wire frame_t enter_pd_word;
	wire frame_t leave_pd_word;
	wire frame_t read_word;
	cmd_t cmd;

	// Three-wire part listens on its shared pin
	assign serial_in = THREE_WIRE ? pins.shared_in : pins.data_in;
	assign sample = pins.cs_low & pins.sclk_rise;
	assign shift_out = pins.cs_low & pins.sclk_fall & rose_reg;
	assign length_ok = (count_reg == COUNT_ZERO) & full_word_reg;
	assign frame_ok = pins.cs_rise & length_ok;

	assign opcode = shift_reg[OPCODE_HI:OPCODE_LO];
	assign read_op = THREE_WIRE ? SA_READ_OP : DC_READ_OP;
	assign write_op = THREE_WIRE ? SA_WRITE_OP : DC_WRITE_OP;
	assign enter_pd_word = THREE_WIRE ? SA_ENTER_PD : DC_ENTER_PD;
	assign leave_pd_word = THREE_WIRE ? SA_LEAVE_PD : DC_LEAVE_PD;
	assign read_word = {READ_PAD, gain_reg, channel_reg};

	// Command decode; no-op and unknown words fall to CMD_NONE
	always_comb begin
		cmd = CMD_NONE;
		if (shift_reg == enter_pd_word) begin
			cmd = CMD_ENTER_PD;
		end else if (shift_reg == leave_pd_word) begin
			cmd = CMD_LEAVE_PD;
		end else if (opcode == write_op) begin
			cmd = CMD_WRITE;
		end else if (opcode == read_op && shift_reg[GAIN_HI:CHAN_LO] == READ_PAD) begin
			cmd = CMD_READ;
		end
	end

	// Frame start after a read preloads read data, else shifts MSB first
	always_comb begin
		shift_next = shift_reg;
		if (pins.cs_fall && read_pending_reg) begin
			shift_next = read_word;
		end else if (sample) begin
			shift_next = {shift_reg[FRAME_BITS-2:0], serial_in};
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			shift_reg <= FRAME_RESET;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// Bit counter restarts at every frame start
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_reg <= COUNT_ZERO;
			full_word_reg <= 1'b0;
			rose_reg <= 1'b0;
		end else if (pins.cs_fall) begin
			count_reg <= COUNT_ZERO;
			full_word_reg <= 1'b0;
			rose_reg <= 1'b0;
		end else if (sample) begin
			count_reg <= count_reg + 1'b1;
			full_word_reg <= full_word_reg | (count_reg == COUNT_W'(FRAME_BITS - 1));
			rose_reg <= 1'b1;
		end
	end

	// Configuration changes only on an accepted frame
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			gain_reg <= GAIN_RESET;
			channel_reg <= CHANNEL_RESET;
			power_down_reg <= 1'b0;
			read_pending_reg <= 1'b0;
		end else if (frame_ok) begin
			read_pending_reg <= (cmd == CMD_READ);
			case (cmd)
				CMD_WRITE: begin
					gain_reg <= shift_reg[GAIN_HI:GAIN_LO];
					channel_reg <= shift_reg[CHAN_HI:CHAN_LO];
					power_down_reg <= 1'b0;
				end
				CMD_ENTER_PD: begin
					power_down_reg <= 1'b1;
				end
				CMD_LEAVE_PD: begin
					power_down_reg <= 1'b0;
				end
				default: begin
					power_down_reg <= power_down_reg;
				end
			endcase
		end
	end

	// Serial output: MSB at frame start, then one bit per falling edge after the first rising edge
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dout_reg <= 1'b0;
		end else if (pins.cs_fall) begin
			dout_reg <= shift_next[FRAME_BITS-1];
		end else if (shift_out) begin
			dout_reg <= shift_reg[FRAME_BITS-1];
		end
	end

	// Output enables follow chip select; the shared pin enable also needs a pending read
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dout_oe_reg <= 1'b0;
			shared_oe_reg <= 1'b0;
			shared_out_reg <= 1'b0;
		end else begin
			dout_oe_reg <= ~THREE_WIRE & pins.cs_low;
			shared_oe_reg <= THREE_WIRE & pins.cs_low & read_pending_reg;
			shared_out_reg <= dout_reg;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			accepted_reg <= 1'b0;
		end else begin
			accepted_reg <= frame_ok;
		end
	end

	assign dout = dout_reg;
	assign dout_oe = dout_oe_reg;
	assign shared_data_pin_out = shared_out_reg;
	assign shared_data_pin_oe = shared_oe_reg;
	assign gain_code = gain_reg;
	assign channel_code = channel_reg;
	assign power_down = power_down_reg;
	assign frame_accepted = accepted_reg;
endmodule

// ===== verilog/spi_gm_pkg.sv
// Constants for the serial gain and channel command port.
// Assumes 16-bit frames; shared by the pin front end and the core.
package spi_gm_pkg;
	localparam int FRAME_BITS = 16;
	localparam int COUNT_W = 4;
	localparam int SYNC_W = 3;
	localparam logic [COUNT_W-1:0] COUNT_ZERO = 4'h0;

	// Frame fields
	localparam int OPCODE_HI = 15;
	localparam int OPCODE_LO = 8;
	localparam int GAIN_HI = 7;
	localparam int GAIN_LO = 4;
	localparam int CHAN_HI = 3;
	localparam int CHAN_LO = 0;

	typedef logic [3:0] gain_code_t;
	typedef logic [3:0] channel_code_t;
	typedef logic [FRAME_BITS-1:0] frame_t;

	localparam gain_code_t GAIN_RESET = 4'h0;
	localparam channel_code_t CHANNEL_RESET = 4'h0;
	localparam frame_t FRAME_RESET = 16'h0000;

	// Standalone (three-wire) command set
	localparam logic [7:0] SA_READ_OP = 8'h6A;
	localparam logic [7:0] SA_WRITE_OP = 8'h2A;
	localparam frame_t SA_NOP = 16'h0000;
	localparam frame_t SA_LEAVE_PD = 16'hE100;
	localparam frame_t SA_ENTER_PD = 16'hE1F1;

	// Daisy-chain (four-wire) command set
	localparam logic [7:0] DC_READ_OP = 8'h7A;
	localparam logic [7:0] DC_WRITE_OP = 8'h3A;
	localparam frame_t DC_NOP = 16'h1000;
	localparam frame_t DC_LEAVE_PD = 16'hF100;
	localparam frame_t DC_ENTER_PD = 16'hF1F1;
	localparam logic [7:0] READ_PAD = 8'h00;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_READ = 3'b001,
		CMD_WRITE = 3'b010,
		CMD_ENTER_PD = 3'b011,
		CMD_LEAVE_PD = 3'b100
	} cmd_t;
endpackage

// ===== verilog/spi_pins_if.sv
// Carrier of synchronised serial pin events from the front end to the core.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface spi_pins_if;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic data_in;
	logic shared_in;

	modport front_end (output sclk_rise, sclk_fall, cs_low, cs_fall, cs_rise, data_in, shared_in);
	modport core (input sclk_rise, sclk_fall, cs_low, cs_fall, cs_rise, data_in, shared_in);
endinterface

// ===== verilog/spi_pin_sync.sv
// Two-flop synchronisers and edge finders for the serial pins.
// Assumes pins are asynchronous to sys_clk and change far slower than it.
`timescale 1ns/1ns
module spi_pin_sync
	import spi_gm_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic shared_in_pin,
	spi_pins_if.front_end pins
);
	localparam int NPIN = 4;

	logic [NPIN-1:0] raw;
	logic [NPIN-1:0] meta_reg;
	logic [NPIN-1:0] stable_reg;
	logic [NPIN-1:0] last_reg;

	assign raw = {shared_in_pin, din, cs_n, sclk};

	// Stage one is read only by stage two
	genvar i;
	generate
		for (i = 0; i < NPIN; i++) begin : g_sync
			always_ff @(posedge sys_clk or posedge reset) begin
				if (reset) begin
					meta_reg[i] <= 1'b1;
					stable_reg[i] <= 1'b1;
					last_reg[i] <= 1'b1;
				end else begin
					meta_reg[i] <= raw[i];
					stable_reg[i] <= meta_reg[i];
					last_reg[i] <= stable_reg[i];
				end
			end
		end
	endgenerate

	assign pins.sclk_rise = stable_reg[0] & ~last_reg[0];
	assign pins.sclk_fall = ~stable_reg[0] & last_reg[0];
	assign pins.cs_low = ~stable_reg[1];
	assign pins.cs_fall = ~stable_reg[1] & last_reg[1];
	assign pins.cs_rise = stable_reg[1] & ~last_reg[1];
	assign pins.data_in = stable_reg[2];
	assign pins.shared_in = stable_reg[3];
endmodule

// ===== dv/spi_gm_monitor.sv
// Checker for the serial gain and channel port, bound to its top module.
// Assumes sys_clk samples the pins; pins held steady for 4+ clocks each.
`timescale 1ns/1ns
module spi_gm_monitor
	import spi_gm_pkg::*;
#(
	parameter bit THREE_WIRE = 1'b0
)(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic shared_data_pin_in,
	input wire logic shared_data_pin_out,
	input wire logic shared_data_pin_oe,
	input wire spi_gm_pkg::gain_code_t gain_code,
	input wire spi_gm_pkg::channel_code_t channel_code,
	input wire logic power_down,
	input wire logic frame_accepted
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_RST_CFG: assert property ($fell(reset) |->
		gain_code == GAIN_RESET && channel_code == CHANNEL_RESET && !power_down) else $error("config not cleared");
	AST_OE_OFF: assert property (cs_n [*6] |-> !dout_oe) else $error("dout driven while deselected");
	AST_OE_ON: assert property (!cs_n [*6] |-> dout_oe == !THREE_WIRE) else $error("dout drive wrong while selected");
	AST_OE_SEL: assert property (dout_oe |-> !$past(cs_n, 3)) else $error("dout driven without select");
	AST_SHARED_OFF: assert property (cs_n [*6] |-> !shared_data_pin_oe) else $error("shared pin driven");
	AST_CFG_AT_CS: assert property (!$stable({gain_code, channel_code, power_down}) |-> $past(cs_n, 2))
		else $error("config changed inside frame");
	AST_CFG_ACC: assert property (!$stable({gain_code, channel_code, power_down}) |-> frame_accepted)
		else $error("config changed without accepted frame");
	AST_ACC_PULSE: assert property (frame_accepted |=> !frame_accepted) else $error("accept pulse too long");
	AST_ACC_CS: assert property (frame_accepted |-> cs_n && $past(cs_n, 2)) else $error("accept before cs rise");
	AST_DOUT_HOLD: assert property ($rose(sclk) && !cs_n ##1 (sclk && !cs_n) [*3] |-> dout == $past(dout, 3))
		else $error("dout moved clock high");
endmodule
bind spi_gain_mux_slave_daisy spi_gm_monitor #(.THREE_WIRE(THREE_WIRE)) mon (.sys_clk, .reset, .sclk, .cs_n, .din,
	.dout, .dout_oe,
	.shared_data_pin_in, .shared_data_pin_out, .shared_data_pin_oe, .gain_code, .channel_code, .power_down,
	.frame_accepted);

// ===== dv/spi_host_model.sv
// Host SPI master model: one 64 ns serial clock, shared select, MSB first.
// Assumes sys_clk at 8 ns; every pin change falls on a sys_clk falling edge.
`timescale 1ns/1ns
module spi_host_model (
	input wire logic sys_clk,
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	logic [63:0] cap = '0;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Sends the low n bits of w; m picks mode 1,1 when high
	task automatic xfer(input logic [63:0] w, input int n, input logic m);
		sclk = m;
		gap(4);
		cs_n = 1'b0;
		gap(12);
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			din = w[i];
			gap(4);
			sclk = 1'b1;
			gap(4);
			cap = {cap[62:0], dout};
		end
		sclk = m;
		gap(4);
		cs_n = 1'b1;
		din = 1'b0;
		gap(12);
	endtask
endmodule

// ===== dv/spi_gain_mux_slave_daisy_bench.sv
// Self-checking bench for the four-wire and three-wire serial gain and channel ports.
// Assumes the host model drives the pins; only the three-wire part uses its shared pin.
`timescale 1ns/1ns
module spi_gain_mux_slave_daisy_bench;
	import spi_gm_pkg::*;
	typedef struct {frame_t w; gain_code_t g; channel_code_t c; logic p;} row_t;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic sclk, cs_n, din, dout, dout_oe, shared_data_pin_out, shared_data_pin_oe, power_down, frame_accepted;
	gain_code_t gain_code;
	channel_code_t channel_code;
	logic chain_mid, shared_oe_3w, pd_3w;
	gain_code_t gain_3w;
	channel_code_t chan_3w;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	row_t rows[8] = '{'{16'h3A53, 4'h5, 4'h3, 1'b0}, '{16'hF1F1, 4'h5, 4'h3, 1'b1}, '{16'h1000, 4'h5, 4'h3, 1'b1},
		'{16'hF100, 4'h5, 4'h3, 1'b0}, '{16'hF1F1, 4'h5, 4'h3, 1'b1}, '{16'h3A7C, 4'h7, 4'hC, 1'b0},
		'{16'h2A11, 4'h7, 4'hC, 1'b0}, '{16'hE1F1, 4'h7, 4'hC, 1'b0}};
	spi_gain_mux_slave_daisy #(.THREE_WIRE(1'b0)) DUT (.sys_clk, .reset, .sclk, .cs_n, .din, .dout, .dout_oe,
		.shared_data_pin_in(din), .shared_data_pin_out, .shared_data_pin_oe, .gain_code, .channel_code,
		.power_down, .frame_accepted);
	// Released dout falls to the next input's pull-down level
	assign chain_mid = dout_oe ? dout : 1'b0;
	// Three-wire part as last device of a write-only chain
	spi_gain_mux_slave_daisy #(.THREE_WIRE(1'b1)) DUT_3W (.sys_clk, .reset, .sclk, .cs_n, .din, .dout(),
		.dout_oe(), .shared_data_pin_in(chain_mid), .shared_data_pin_out(), .shared_data_pin_oe(shared_oe_3w),
		.gain_code(gain_3w), .channel_code(chan_3w), .power_down(pd_3w), .frame_accepted());
	spi_host_model host (.sys_clk, .sclk, .cs_n, .din, .dout);
	always #4 sys_clk = ~sys_clk;
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cfg(input gain_code_t g, input channel_code_t c, input logic p);
		chk("config", 16'({gain_code, channel_code, power_down}), 16'({g, c, p}));
	endtask
	task automatic cfg3(input gain_code_t g, input channel_code_t c, input logic p);
		chk("config_3w", 16'({gain_3w, chan_3w, pd_3w}), 16'({g, c, p}));
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		host.gap(8);
		reset = 1'b0;
		host.gap(8);
		cfg(4'h0, 4'h0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			host.xfer(64'(rows[i].w), 16, i[0]);
			cfg(rows[i].g, rows[i].c, rows[i].p);
		end
		cfg3(4'h1, 4'h1, 1'b0);
		$display("test command rows done");
		// Lengths one short and one past a word
		host.xfer(64'h3A11, 15, 1'b0);
		cfg(4'h7, 4'hC, 1'b0);
		host.xfer(64'h3A11, 17, 1'b1);
		cfg(4'h7, 4'hC, 1'b0);
		cfg3(4'h1, 4'h1, 1'b0);
		$display("test odd lengths done");
		host.xfer(64'h3A22_3A99, 32, 1'b0);
		cfg(4'h9, 4'h9, 1'b0);
		chk("passthrough", host.cap[15:0], 16'h3A22);
		$display("test chain frame done");
		host.xfer(64'h7A00, 16, 1'b1);
		host.xfer(64'h1000, 16, 1'b0);
		chk("readback", host.cap[15:0], {READ_PAD, 4'h9, 4'h9});
		cfg(4'h9, 4'h9, 1'b0);
		$display("test read done");
		// Standalone codes reach the chain's last device
		host.xfer(64'hE1F1_1000, 32, 1'b1);
		cfg(4'h9, 4'h9, 1'b0);
		cfg3(4'h1, 4'h1, 1'b1);
		fork
			host.xfer(64'h2A3C_1000, 32, 1'b0);
			begin
				host.gap(40);
				chk("shared_oe_3w", 16'(shared_oe_3w), 16'h0000);
				chk("shared_oe_4w", 16'(shared_data_pin_oe), 16'h0000);
			end
		join
		cfg3(4'h3, 4'hC, 1'b0);
		$display("test chain end done");
		reset = 1'b1;
		host.gap(3);
		reset = 1'b0;
		host.gap(8);
		cfg(4'h0, 4'h0, 1'b0);
		cfg3(4'h0, 4'h0, 1'b0);
		$display("test reset done");
		end_of_test();
	end
endmodule
